//--- logic/dsecc_pkg.sv
// Shared constants, carrier types and code functions for the DRAM SEC-DED ECC block
`default_nettype none
package dsecc_pkg;

  localparam int DATA_W = 32;
  localparam int CHK_W = 7;
  localparam int LANE_W = 64;
  localparam int BE_W = 4;
  localparam int INT_W = 7;

  // Check lanes sit just above the data lanes once half-datapath mode frees them
  localparam int CHK_LSB = 32;
  localparam int CHK_MSB = 38;

  localparam logic [6:0] SYND_NONE = 7'h00;
  localparam logic [3:0] BE_FULL = 4'hF;
  localparam logic [31:0] WORD_ALIGN_MASK = 32'hFFFF_FFFC;

  // Flipping two check bits turns the stored code into a double-error signature
  localparam logic [6:0] POISON_PAT = 7'h03;

  localparam int ST_CORR_1 = 3;
  localparam int ST_CORR_2 = 4;
  localparam int ST_UNC_1 = 5;
  localparam int ST_UNC_2 = 6;
  localparam logic [6:0] INT_STATUS_RST = 7'h00;
  localparam logic [31:0] WORD_RST = 32'h0000_0000;

  // Syndrome produced by a single flip of data bit i (index 0 first)
  localparam logic [6:0] DATA_SYND [32] = '{
    7'h75, 7'h70, 7'h6D, 7'h6B, 7'h68, 7'h67, 7'h64, 7'h62,
    7'h5E, 7'h5B, 7'h58, 7'h57, 7'h54, 7'h52, 7'h4F, 7'h4A,
    7'h34, 7'h31, 7'h2C, 7'h2A, 7'h29, 7'h26, 7'h25, 7'h23,
    7'h1C, 7'h1A, 7'h19, 7'h16, 7'h15, 7'h13, 7'h0E, 7'h0B};

  typedef struct packed {
    logic [6:0] chk;
    logic [31:0] data;
  } dsecc_word_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] data;
    logic [6:0] synd;
  } dsecc_sig_t;

  // Check code of a 32-bit word: each set data bit contributes its syndrome
  function automatic logic [6:0] dsecc_gen_check(input logic [31:0] data);
    logic [6:0] code;
    code = SYND_NONE;
    for (int i = 0; i < DATA_W; i++) begin
      if (data[i]) begin
        code = code ^ DATA_SYND[i];
      end
    end
    return code;
  endfunction

  // Byte merge for read-modify-write: enabled lanes take the new bytes
  function automatic logic [31:0] dsecc_merge(input logic [31:0] old_d, input logic [31:0] new_d,
                                              input logic [3:0] be);
    logic [31:0] res;
    res = old_d;
    for (int b = 0; b < BE_W; b++) begin
      if (be[b]) begin
        res[b*8 +: 8] = new_d[b*8 +: 8];
      end
    end
    return res;
  endfunction

endpackage
`default_nettype wire

//--- logic/dsecc_decode.sv
// Syndrome decoder: classifies a read word and corrects a single flipped data bit
`default_nettype none
module dsecc_decode
  import dsecc_pkg::*;
(
  input wire dsecc_pkg::dsecc_word_t rd_word,
  output logic [6:0] synd,
  output logic [31:0] fixed_data,
  output logic corr_err,
  output logic unc_err
);

  import dsecc_pkg::*;

  logic [31:0] flip_mask;
  logic chk_single;

  assign synd = dsecc_gen_check(rd_word.data) ^ rd_word.chk; // see [RL20]

  always_comb begin
    flip_mask = WORD_RST;
    for (int i = 0; i < DATA_W; i++) begin
      flip_mask[i] = (synd == DATA_SYND[i]); // see [RL6]
    end
  end

  // A lone check-bit error leaves a one-hot syndrome and needs no data fix
  assign chk_single = (synd != SYND_NONE) && ((synd & (synd - 7'h01)) == SYND_NONE);
  assign fixed_data = rd_word.data ^ flip_mask; // see [RL6]
  assign corr_err = chk_single || (flip_mask != WORD_RST); // see [RL6]
  // Three or more flips may alias; they land here, in the correctable class or, from four flips on, with a zero syndrome
  assign unc_err = (synd != SYND_NONE) && !corr_err; // see [RL7] see [RL24]

endmodule
`default_nettype wire

//--- logic/dsecc_top.sv
// DRAM SEC-DED ECC datapath, read-modify-write sequencer, signatures and ECC status
// Function
// [RL1] Keep 7-bit check code per aligned 32-bit word
// [RL2] Word alignment and coverage decide internal processing
// [RL3] ECC disabled: no check code computed or written
// [RL4] Every read checks data and check bits
// [RL5] Check codes never cross the host interface
// [RL6] Single-bit error corrected by syndrome-located flip
// [RL7] Double-bit error flagged uncorrectable, never corrected
// [RL8] Reads return corrected data, memory untouched; RMW rewrites
// [RL9] Fully masked write scrubs word with correction
// [RL10] RMW uncorrectable read poisons stored check code
// [RL11] Write check XORs programmed pattern into code
// [RL12] Separate correctable and uncorrectable error signatures
// [RL13] Signature address rounded down to word boundary
// [RL14] Signature held until read; later ones dropped
// [RL15] Four ECC status bits, cleared by reset
// [RL16] Second-error bits need unacknowledged first error
// [RL17] Interrupt asserts for set, unmasked status bits
// [RL18] ECC needs half datapath; check on freed lanes
// [RL19] Per-lane disables ignore memory datapath bits
// [RL20] Syndrome is generated XOR stored; nonzero errs
// [RL21] Correctable error sets bit 3, then 4
// [RL22] Partial write reads, merges, regenerates check code
// [RL23] Acknowledge one clears status; zero does nothing
// [RL24] Beyond two flipped bits, classification is unguaranteed
`default_nettype none
module dsecc_top
  import dsecc_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic ECC_EN,
  input wire logic ECC_REPORT_EN,
  input wire logic ECC_CORRECT_EN,
  input wire logic ECC_POISON_EN,
  input wire logic ECC_WR_CHECK_EN,
  input wire logic [6:0] ECC_XOR_PAT,
  input wire logic HALF_DATAPATH_SEL,
  input wire logic [63:0] LANE_DIS,
  input wire logic HOST_REQ,
  input wire logic HOST_WR,
  input wire logic [31:0] HOST_ADDR,
  input wire logic [31:0] HOST_WDATA,
  input wire logic [3:0] HOST_BE,
  output logic HOST_READY,
  output logic HOST_WACK,
  output logic HOST_RVALID,
  output logic [31:0] HOST_RDATA,
  output logic MEM_REQ,
  output logic MEM_WR,
  output logic [31:0] MEM_ADDR,
  output logic [3:0] MEM_BE,
  output logic [63:0] MEM_WDQ,
  input wire logic MEM_READY,
  input wire logic MEM_RVALID,
  input wire logic [63:0] MEM_RDQ,
  input wire logic [6:0] INT_ACK,
  input wire logic [6:0] INT_MASK,
  output logic [6:0] INT_STATUS,
  output logic MEM_CTRL_IRQ_OUT,
  input wire logic SIG_C_READ,
  input wire logic SIG_U_READ,
  output dsecc_pkg::dsecc_sig_t SIG_C,
  output dsecc_pkg::dsecc_sig_t SIG_U,
  output logic SIG_C_VALID,
  output logic SIG_U_VALID
);

  import dsecc_pkg::*;

  typedef enum logic [1:0] {S_IDLE, S_RD_REQ, S_RD_WAIT, S_WR_REQ} dsecc_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // State and registers

  dsecc_state_t state_q;
  dsecc_state_t state_d;
  logic op_wr_q;
  logic [31:0] addr_q;
  logic [31:0] wdata_q;
  logic [3:0] be_q;
  logic [3:0] mem_be_q;
  logic [63:0] mem_wdq_q;
  logic [31:0] rdata_q;
  logic rvalid_q;
  logic poison_q;
  logic [6:0] status_q;
  logic [6:0] status_d;
  dsecc_sig_t c_sig_q;
  dsecc_sig_t u_sig_q;
  logic c_valid_q;
  logic u_valid_q;

  ////////////////////////////////////////////////////////////////////////////
  // Decode and datapath

  // First/second status pair update; the new event beats a same-cycle ack
  function automatic logic [1:0] pair_next(input logic [1:0] cur, input logic ev, input logic [1:0] ack);
    logic [1:0] nxt;
    nxt = cur & ~ack; // see [RL23]
    if (ev && cur[0]) begin
      nxt[1] = 1'b1; // see [RL16]
    end else if (ev) begin
      nxt[0] = 1'b1;
    end
    return nxt;
  endfunction

  // Lay a word onto the memory lanes, check code on the freed upper half
  function automatic logic [63:0] pack_lanes(input logic [31:0] data, input logic [6:0] chk,
                                             input logic with_chk, input logic [63:0] dis);
    logic [63:0] lanes;
    lanes = {32'h0000_0000, data};
    if (with_chk) begin
      lanes[CHK_MSB:CHK_LSB] = chk; // see [RL18]
    end
    return lanes & ~dis; // see [RL19]
  endfunction

  wire ecc_on = ECC_EN && HALF_DATAPATH_SEL; // see [RL18]
  wire host_take = HOST_REQ && HOST_READY;
  // With ECC on, a write short of all four byte enables needs the old word first
  wire need_read = !HOST_WR || (ecc_on && (HOST_BE != BE_FULL)); // see [RL2] see [RL22]
  wire rd_done = (state_q == S_RD_WAIT) && MEM_RVALID;
  wire wr_done = (state_q == S_WR_REQ) && MEM_READY;

  wire [63:0] rd_lanes = MEM_RDQ & ~LANE_DIS; // see [RL19]
  dsecc_word_t rd_word;
  assign rd_word.data = rd_lanes[31:0];
  assign rd_word.chk = rd_lanes[CHK_MSB:CHK_LSB];

  logic [6:0] synd;
  logic [31:0] fixed_data;
  logic corr_err;
  logic unc_err;

  dsecc_decode u_decode (
    .rd_word(rd_word),
    .synd(synd),
    .fixed_data(fixed_data),
    .corr_err(corr_err),
    .unc_err(unc_err)
  );

  wire check_rd = rd_done && ecc_on; // see [RL4]
  wire corr_ev = check_rd && ECC_REPORT_EN && corr_err;
  wire unc_ev = check_rd && ECC_REPORT_EN && unc_err; // see [RL7]
  // Uncorrectable data passes through raw; only single flips are repaired
  wire use_fix = ecc_on && ECC_CORRECT_EN && corr_err;
  wire [31:0] good_data = use_fix ? fixed_data : rd_word.data; // see [RL6] see [RL8]

  // Fully masked write merges nothing, so the corrected old word is rewritten
  wire [31:0] merged = dsecc_merge(good_data, wdata_q, be_q); // see [RL9] see [RL22]
  wire poison_now = ecc_on && ECC_POISON_EN && unc_err; // see [RL10]
  wire [6:0] force_pat = ECC_WR_CHECK_EN ? ECC_XOR_PAT : SYND_NONE; // see [RL11]
  wire [6:0] rmw_chk = dsecc_gen_check(merged) ^ (poison_now ? POISON_PAT : SYND_NONE) ^ force_pat;
  wire [6:0] new_chk = dsecc_gen_check(HOST_WDATA) ^ force_pat; // see [RL1] see [RL11]

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer

  always_comb begin
    state_d = state_q;
    case (state_q)
      S_IDLE: begin
        if (host_take) begin
          state_d = need_read ? S_RD_REQ : S_WR_REQ;
        end
      end
      S_RD_REQ: begin
        if (MEM_READY) begin
          state_d = S_RD_WAIT;
        end
      end
      S_RD_WAIT: begin
        if (MEM_RVALID) begin
          state_d = op_wr_q ? S_WR_REQ : S_IDLE; // see [RL22]
        end
      end
      S_WR_REQ: begin
        if (MEM_READY) begin
          state_d = S_IDLE;
        end
      end
      default: begin
        state_d = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      state_q <= S_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      op_wr_q <= 1'b0;
      addr_q <= WORD_RST;
      wdata_q <= WORD_RST;
      be_q <= 4'h0;
    end else if (host_take) begin
      op_wr_q <= HOST_WR;
      addr_q <= HOST_ADDR & WORD_ALIGN_MASK; // see [RL2]
      wdata_q <= HOST_WDATA;
      be_q <= HOST_BE;
    end
  end

  // Write lanes: direct write (full word, or any byte enables with ECC off), or the merged RMW word
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      mem_wdq_q <= 64'h0000_0000_0000_0000;
      mem_be_q <= 4'h0;
      poison_q <= 1'b0;
    end else if (host_take && !need_read) begin
      mem_wdq_q <= pack_lanes(HOST_WDATA, new_chk, ecc_on, LANE_DIS); // see [RL3]
      mem_be_q <= ecc_on ? BE_FULL : HOST_BE;
      poison_q <= 1'b0;
    end else if (rd_done && op_wr_q) begin
      mem_wdq_q <= pack_lanes(merged, rmw_chk, ecc_on, LANE_DIS); // see [RL8] see [RL10]
      mem_be_q <= BE_FULL; // see [RL9]
      poison_q <= poison_now;
    end
  end

  // Read return: data lanes only, the check code stays inside
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      rdata_q <= WORD_RST;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= rd_done && !op_wr_q;
      if (rd_done && !op_wr_q) begin
        rdata_q <= good_data; // see [RL5] see [RL8]
      end
    end
  end

  assign HOST_READY = (state_q == S_IDLE);
  assign HOST_WACK = wr_done;
  assign HOST_RVALID = rvalid_q;
  assign HOST_RDATA = rdata_q;
  assign MEM_REQ = (state_q == S_RD_REQ) || (state_q == S_WR_REQ);
  assign MEM_WR = (state_q == S_WR_REQ);
  assign MEM_ADDR = addr_q;
  assign MEM_BE = MEM_WR ? mem_be_q : BE_FULL;
  assign MEM_WDQ = mem_wdq_q;

  ////////////////////////////////////////////////////////////////////////////
  // Status, interrupt and signatures

  always_comb begin
    status_d = status_q;
    status_d[ST_CORR_2:ST_CORR_1] = pair_next(status_q[ST_CORR_2:ST_CORR_1], corr_ev,
                                              INT_ACK[ST_CORR_2:ST_CORR_1]); // see [RL21]
    status_d[ST_UNC_2:ST_UNC_1] = pair_next(status_q[ST_UNC_2:ST_UNC_1], unc_ev,
                                            INT_ACK[ST_UNC_2:ST_UNC_1]);
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      status_q <= INT_STATUS_RST; // see [RL15]
    end else begin
      status_q <= status_d;
    end
  end

  assign INT_STATUS = status_q;
  assign MEM_CTRL_IRQ_OUT = |(status_q & ~INT_MASK); // see [RL17]

  // A capture in the cycle of the read strobe keeps the fresh signature
  wire c_cap = corr_ev && (!c_valid_q || SIG_C_READ); // see [RL14]
  wire u_cap = unc_ev && (!u_valid_q || SIG_U_READ); // see [RL14]
  dsecc_sig_t ev_sig;
  assign ev_sig.addr = addr_q & WORD_ALIGN_MASK; // see [RL13]
  assign ev_sig.data = rd_word.data;
  assign ev_sig.synd = synd;

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      c_sig_q <= '0;
      u_sig_q <= '0;
      c_valid_q <= 1'b0;
      u_valid_q <= 1'b0;
    end else begin
      c_valid_q <= c_cap || (c_valid_q && !SIG_C_READ);
      u_valid_q <= u_cap || (u_valid_q && !SIG_U_READ);
      if (c_cap) begin
        c_sig_q <= ev_sig; // see [RL12]
      end
      if (u_cap) begin
        u_sig_q <= ev_sig; // see [RL12]
      end
    end
  end

  assign SIG_C = c_sig_q;
  assign SIG_U = u_sig_q;
  assign SIG_C_VALID = c_valid_q;
  assign SIG_U_VALID = u_valid_q;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  sequence s_partial_wr;
    host_take && HOST_WR && ecc_on && (HOST_BE != BE_FULL);
  endsequence

  sequence s_mem_read;
    MEM_REQ && !MEM_WR;
  endsequence

  rmw_read_first_a: assert property (s_partial_wr |=> s_mem_read) // see [RL22]
    else $error("partial write did not start with a read");

  rmw_write_back_a: assert property (rd_done && op_wr_q |=> MEM_REQ && MEM_WR && (MEM_BE == BE_FULL)) // see [RL8]
    else $error("read phase of a write was not followed by a full write");

  no_chk_off_a: assert property (host_take && HOST_WR && !ecc_on
                                 |=> MEM_WR && (MEM_WDQ[CHK_MSB:CHK_LSB] == SYND_NONE)) // see [RL3]
    else $error("check lanes written while ECC was off");

  corr_first_a: assert property (corr_ev && !status_q[ST_CORR_1] |=> status_q[ST_CORR_1] && !$rose(status_q[ST_CORR_2])) // see [RL21]
    else $error("first correctable error did not set status bit 3 alone");

  corr_second_a: assert property (corr_ev && status_q[ST_CORR_1] |=> status_q[ST_CORR_2]) // see [RL16]
    else $error("second correctable error did not set status bit 4");

  unc_second_a: assert property (!unc_ev |=> !$rose(status_q[ST_UNC_2])) // see [RL16]
    else $error("status bit 6 rose without an uncorrectable error");

  ack_clear_a: assert property (INT_ACK[ST_UNC_1] && !unc_ev |=> !status_q[ST_UNC_1]) // see [RL23]
    else $error("acknowledge did not clear status bit 5");

  irq_raise_a: assert property (corr_ev && !INT_MASK[ST_CORR_1] && !INT_ACK[ST_CORR_1]
                                |=> MEM_CTRL_IRQ_OUT) // see [RL17]
    else $error("unmasked correctable error did not raise the interrupt");

  sig_hold_a: assert property (c_valid_q && !SIG_C_READ |=> $stable(c_sig_q) && c_valid_q) // see [RL14]
    else $error("held correctable signature changed before it was read");

  sig_align_a: assert property (u_cap |=> (SIG_U.addr[1:0] == 2'b00) && (SIG_U.synd == $past(synd))) // see [RL13]
    else $error("uncorrectable signature not word aligned or syndrome lost");

  rd_fix_a: assert property (rd_done && !op_wr_q && ecc_on && ECC_CORRECT_EN && corr_err
                             |=> HOST_RVALID && (dsecc_gen_check(HOST_RDATA) ^ $past(rd_word.chk)) != $past(synd)
                                 || ($past(synd) & ($past(synd) - 7'h01)) == SYND_NONE) // see [RL6]
    else $error("correctable read returned uncorrected data");

  poison_a: assert property (MEM_WR && poison_q && !ECC_WR_CHECK_EN
                             |-> MEM_WDQ[CHK_MSB:CHK_LSB] != (dsecc_gen_check(MEM_WDQ[31:0]) & ~LANE_DIS[CHK_MSB:CHK_LSB])) // see [RL10]
    else $error("uncorrectable RMW word written with a clean check code");

endmodule
`default_nettype wire

//--- dv/dsecc_mem_model.sv
// Behavioural DRAM model answering the ECC block's memory port
`default_nettype none
module dsecc_mem_model (
  input wire logic clk,
  input wire logic slow,
  input wire logic mem_req,
  input wire logic mem_wr,
  input wire logic [31:0] mem_addr,
  input wire logic [3:0] mem_be,
  input wire logic [63:0] mem_wdq,
  output logic mem_ready,
  output logic mem_rvalid,
  output logic [63:0] mem_rdq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [63:0] mem [logic [31:0]];
  logic [31:0] last_key = 32'h0;
  logic [63:0] rd_word = 64'h0;
  logic [63:0] w = 64'h0;
  int rd_due = -1;
  int cnt = 0;
  initial begin
    mem_ready = 1'b0;
    mem_rvalid = 1'b0;
    mem_rdq = 64'h0;
  end
  //////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    if (mem_req === 1'b1 && mem_ready) begin
      cnt = 0;
      last_key = mem_addr;
      w = mem.exists(mem_addr) ? mem[mem_addr] : 64'h0;
      if (mem_wr) begin
        // Byte enables guard data lanes only; check lanes always land
        for (int b = 0; b < 4; b++) begin
          if (mem_be[b]) w[b*8 +: 8] = mem_wdq[b*8 +: 8];
        end
        w[63:32] = mem_wdq[63:32];
        mem[mem_addr] = w;
      end else begin
        rd_word = w;
        rd_due = slow ? 3 : 0;
      end
    end
  end
  // Falling-edge drive keeps the design's sampling free of races
  always @(negedge clk) begin
    mem_rvalid = (rd_due == 0);
    // Outside a return the lines toggle, so stale data never looks valid
    mem_rdq = (rd_due == 0) ? rd_word : ~mem_rdq;
    if (rd_due >= 0) rd_due--;
    cnt = (mem_req === 1'b1) ? cnt + 1 : 0;
    mem_ready = (mem_req === 1'b1) && (cnt > (slow ? 2 : 0));
  end
endmodule
`default_nettype wire

//--- dv/dsecc_top_bench.sv
// Self-checking bench for the DRAM SEC-DED ECC block
`default_nettype none
module dsecc_top_bench;
  import dsecc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLK = 1'b0, RST_N = 1'b0, slow = 1'b0;
  logic ECC_EN = 1'b1, ECC_REPORT_EN = 1'b1, ECC_CORRECT_EN = 1'b1, ECC_POISON_EN = 1'b1;
  logic ECC_WR_CHECK_EN = 1'b0, HALF_DATAPATH_SEL = 1'b1;
  logic HOST_REQ = 1'b0, HOST_WR = 1'b0, SIG_C_READ = 1'b0, SIG_U_READ = 1'b0;
  logic [6:0] ECC_XOR_PAT = 7'h00, INT_ACK = 7'h00, INT_MASK = 7'h00;
  logic [63:0] LANE_DIS = 64'h0;
  logic [31:0] HOST_ADDR = 32'h0, HOST_WDATA = 32'h0;
  logic [3:0] HOST_BE = 4'h0;
  logic HOST_READY, HOST_WACK, HOST_RVALID, MEM_REQ, MEM_WR, MEM_READY, MEM_RVALID;
  logic MEM_CTRL_IRQ_OUT, SIG_C_VALID, SIG_U_VALID;
  logic [31:0] HOST_RDATA, MEM_ADDR;
  logic [3:0] MEM_BE;
  logic [63:0] MEM_WDQ, MEM_RDQ;
  logic [6:0] INT_STATUS;
  dsecc_sig_t SIG_C, SIG_U;
  int n_errors = 0, n_tests = 0, n_wr = 0, n_wack = 0, k, k2, j, be;
  logic [31:0] rng = 32'h7961E9FC, a, d, d2, m;
  logic [31:0] exp_q [$];
  logic [63:0] w;
  logic [6:0] pat;

  always #2 CLK = ~CLK;

  dsecc_top u_dsecc_top (.CLK(CLK), .RST_N(RST_N), .ECC_EN(ECC_EN), .ECC_REPORT_EN(ECC_REPORT_EN),
    .ECC_CORRECT_EN(ECC_CORRECT_EN), .ECC_POISON_EN(ECC_POISON_EN), .ECC_WR_CHECK_EN(ECC_WR_CHECK_EN),
    .ECC_XOR_PAT(ECC_XOR_PAT), .HALF_DATAPATH_SEL(HALF_DATAPATH_SEL), .LANE_DIS(LANE_DIS),
    .HOST_REQ(HOST_REQ), .HOST_WR(HOST_WR), .HOST_ADDR(HOST_ADDR), .HOST_WDATA(HOST_WDATA),
    .HOST_BE(HOST_BE), .HOST_READY(HOST_READY), .HOST_WACK(HOST_WACK), .HOST_RVALID(HOST_RVALID),
    .HOST_RDATA(HOST_RDATA), .MEM_REQ(MEM_REQ), .MEM_WR(MEM_WR), .MEM_ADDR(MEM_ADDR), .MEM_BE(MEM_BE),
    .MEM_WDQ(MEM_WDQ), .MEM_READY(MEM_READY), .MEM_RVALID(MEM_RVALID), .MEM_RDQ(MEM_RDQ),
    .INT_ACK(INT_ACK), .INT_MASK(INT_MASK), .INT_STATUS(INT_STATUS), .MEM_CTRL_IRQ_OUT(MEM_CTRL_IRQ_OUT),
    .SIG_C_READ(SIG_C_READ), .SIG_U_READ(SIG_U_READ), .SIG_C(SIG_C), .SIG_U(SIG_U),
    .SIG_C_VALID(SIG_C_VALID), .SIG_U_VALID(SIG_U_VALID));

  dsecc_mem_model u_dsecc_mem_model (.clk(CLK), .slow(slow), .mem_req(MEM_REQ), .mem_wr(MEM_WR),
    .mem_addr(MEM_ADDR), .mem_be(MEM_BE), .mem_wdq(MEM_WDQ), .mem_ready(MEM_READY),
    .mem_rvalid(MEM_RVALID), .mem_rdq(MEM_RDQ));

  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction
  // Independent check-code model built from the single-bit syndromes
  function automatic logic [6:0] code_of(input logic [31:0] v);
    logic [6:0] c;
    c = 7'h00;
    for (int i = 0; i < 32; i++) begin
      if (v[i]) c = c ^ DATA_SYND[i];
    end
    return c;
  endfunction
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] b);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (b[i]) r[i*8 +: 8] = n[i*8 +: 8];
    end
    return r;
  endfunction
  function automatic logic [63:0] stored();
    return u_dsecc_mem_model.mem[u_dsecc_mem_model.last_key];
  endfunction
  task automatic flip(input logic [63:0] fm);
    u_dsecc_mem_model.mem[u_dsecc_mem_model.last_key] ^= fm;
  endtask
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] expv);
    n_tests++;
    if (seen !== expv) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, expv, seen);
    end
  endtask
  task automatic give_verdict();
    if (n_errors == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Held until taken, then waits for idle; a hang ends the run
  task automatic xfer(input logic wr, input logic [31:0] ad, input logic [31:0] wd, input logic [3:0] b);
    int i;
    HOST_REQ = 1'b1;
    HOST_WR = wr;
    HOST_ADDR = ad;
    HOST_WDATA = wd;
    HOST_BE = b;
    for (i = 0; i < 50 && HOST_READY !== 1'b1; i++) @(negedge CLK);
    if (i == 50) begin
      n_errors++;
      give_verdict();
    end
    @(negedge CLK);
    HOST_REQ = 1'b0;
    n_wr += int'(wr);
    for (i = 0; i < 50 && HOST_READY !== 1'b1; i++) @(negedge CLK);
    if (i == 50) begin
      n_errors++;
      give_verdict();
    end
    @(negedge CLK);
  endtask
  task automatic rd(input logic [31:0] ad, input logic [31:0] expd);
    exp_q.push_back(expd);
    xfer(1'b0, ad, 32'h0, BE_FULL);
  endtask
  task automatic ack(input logic [6:0] am);
    INT_ACK = am;
    @(negedge CLK);
    INT_ACK = 7'h00;
    @(negedge CLK);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  always @(posedge CLK) begin
    if (HOST_WACK === 1'b1) n_wack++;
  end
  always @(negedge CLK) begin
    if (HOST_RVALID === 1'b1) begin
      if (exp_q.size() == 0) check("spurious read", 64'h1, 64'h0);
      else check("read data", HOST_RDATA, exp_q.pop_front());
    end
  end
  initial begin
    repeat (20000) @(posedge CLK);
    n_errors++;
    give_verdict();
  end

  initial begin
    repeat (3) @(negedge CLK);
    RST_N = 1'b1;
    @(negedge CLK);
    check("status", INT_STATUS, INT_STATUS_RST);
    a = xs();
    d = xs();
    xfer(1'b1, a, d, BE_FULL);
    check("stored", stored(), {25'h0, code_of(d), d});
    rd(a, d);
    check("clean", INT_STATUS, 7'h00);
    slow = 1'b1;
    k = int'(xs() % 32);
    flip(64'h1 << k);
    w = stored();
    rd(a, d);
    check("mem kept", stored(), w);
    check("first corr", INT_STATUS, 7'h08);
    check("irq", MEM_CTRL_IRQ_OUT, 1'b1);
    check("c addr", SIG_C.addr, a & WORD_ALIGN_MASK);
    check("c synd", SIG_C.synd, DATA_SYND[k]);
    check("c data", SIG_C.data, d ^ (32'h1 << k));
    flip(64'h1 << k);
    j = int'(xs() % 7);
    flip(64'h1 << (32 + j));
    rd(a, d);
    check("second corr", INT_STATUS, 7'h18);
    check("c held", SIG_C.synd, DATA_SYND[k]);
    INT_MASK = 7'h18;
    @(negedge CLK);
    check("masked", MEM_CTRL_IRQ_OUT, 1'b0);
    INT_MASK = 7'h00;
    ack(7'h08);
    ack(7'h00);
    check("ack", INT_STATUS, 7'h10);
    SIG_C_READ = 1'b1;
    @(negedge CLK);
    SIG_C_READ = 1'b0;
    @(negedge CLK);
    check("c valid", SIG_C_VALID, 1'b0);
    slow = 1'b0;
    xfer(1'b1, a, xs(), 4'h0);
    check("scrub", stored(), {25'h0, code_of(d), d});
    ack(7'h78);
    k2 = (k + 1) % 32;
    d2 = d ^ (32'h1 << k) ^ (32'h1 << k2);
    flip({32'h0, d ^ d2});
    rd(a, d2);
    check("unc", INT_STATUS, 7'h20);
    check("u synd", SIG_U.synd, DATA_SYND[k] ^ DATA_SYND[k2]);
    check("u addr", SIG_U.addr, a & WORD_ALIGN_MASK);
    check("u data", SIG_U.data, d2);
    check("u valid", SIG_U_VALID, 1'b1);
    m = xs();
    xfer(1'b1, a, m, 4'h3);
    m = merge(d2, m, 4'h3);
    check("poison", stored(), {25'h0, code_of(m) ^ POISON_PAT, m});
    check("second unc", INT_STATUS, 7'h60);
    // Mid-run reset while status and a signature are held
    RST_N = 1'b0;
    @(negedge CLK);
    RST_N = 1'b1;
    @(negedge CLK);
    check("rst status", INT_STATUS, INT_STATUS_RST);
    check("rst irq", MEM_CTRL_IRQ_OUT, 1'b0);
    check("rst sig", SIG_U_VALID, 1'b0);
    ECC_POISON_EN = 1'b0;
    d = xs();
    xfer(1'b1, a, d, 4'h1);
    m = merge(m, d, 4'h1);
    check("no poison", stored(), {25'h0, code_of(m), m});
    ECC_POISON_EN = 1'b1;
    ack(7'h78);
    for (be = 1; be < 15; be++) begin
      d = xs();
      xfer(1'b1, a, d, be[3:0]);
      m = merge(m, d, be[3:0]);
      check("rmw", stored(), {25'h0, code_of(m), m});
    end
    check("rmw status", INT_STATUS, 7'h00);
    // Correction and reporting switched off together, then back on one at a time
    ECC_CORRECT_EN = 1'b0;
    ECC_REPORT_EN = 1'b0;
    flip(64'h2);
    rd(a, m ^ 32'h2);
    check("no report", INT_STATUS, 7'h00);
    ECC_REPORT_EN = 1'b1;
    rd(a, m ^ 32'h2);
    check("raw corr", INT_STATUS, 7'h08);
    check("raw c data", SIG_C.data, m ^ 32'h2);
    ECC_CORRECT_EN = 1'b1;
    ack(7'h08);
    ECC_WR_CHECK_EN = 1'b1;
    d = xs();
    pat = d[6:0];
    ECC_XOR_PAT = pat;
    xfer(1'b1, a, d, BE_FULL);
    check("forced", stored(), {25'h0, code_of(d) ^ pat, d});
    ECC_WR_CHECK_EN = 1'b0;
    ECC_EN = 1'b0;
    HALF_DATAPATH_SEL = 1'b0;
    LANE_DIS = 64'h1;
    d = xs() | 32'h1;
    xfer(1'b1, a, d, BE_FULL);
    check("ecc off", stored(), {32'h0, d & 32'hFFFF_FFFE});
    LANE_DIS = 64'h0;
    d2 = xs();
    xfer(1'b1, a, d2, 4'h5);
    m = merge(d & 32'hFFFF_FFFE, d2, 4'h5);
    check("off bytes", stored(), {32'h0, m});
    flip(64'h1);
    rd(a, m ^ 32'h1);
    check("off status", INT_STATUS, 7'h00);
    check("wack count", n_wack, n_wr);
    give_verdict();
  end
endmodule
`default_nettype wire
